// >>> xmbp_regs.svh
`ifndef XMBP_REGS_SVH
`define XMBP_REGS_SVH
`define XMBP_ADDR_W      24
`define XMBP_DATA_W      16
`define XMBP_SPACES      4
`define XMBP_WIDE_SPACE  2'h3
`define XMBP_ADDR_TOP    23
`define XMBP_IDLE_RST    1'b1
`define XMBP_DATA_MIN    2'h3
`endif

// >>> xmbp_pkg.sv
`default_nettype none
package xmbp_pkg;
  typedef enum logic {XMBP_SPLIT_STROBE, XMBP_SINGLE_STROBE} xmbp_strobe_t;
  typedef enum logic {XMBP_SEPARATE, XMBP_MUXED} xmbp_busmode_t;
  typedef enum logic {XMBP_SINGLE_CHIP, XMBP_MICROPROC} xmbp_procmode_t;
  typedef enum {XMBP_IDLE, XMBP_ADDR, XMBP_DATA, XMBP_HOLD} xmbp_state_t;
endpackage : xmbp_pkg
`default_nettype wire

// >>> xmbp_port.sv
`include "xmbp_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module xmbp_port #(
  parameter int ADDR_W = `XMBP_ADDR_W,
  parameter int DATA_W = `XMBP_DATA_W
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire logic [1:0]           req_space,
  input  wire logic [ADDR_W-1:0]    req_addr,
  input  wire logic [DATA_W-1:0]    req_wdata,
  input  wire logic                 req_word,
  input  wire xmbp_pkg::xmbp_strobe_t  strobe_scheme,
  input  wire xmbp_pkg::xmbp_busmode_t bus_mode,
  input  wire logic [2:0]           narrow_spaces,
  input  wire logic                 width_strap,
  input  wire logic                 boot_mode_strap,
  input  wire logic                 hold_req_n,
  input  wire logic                 ready,
  input  wire logic [DATA_W-1:0]    data_in,
  output logic                      req_ready,
  output logic                      rsp_valid,
  output logic [DATA_W-1:0]         rsp_rdata,
  output logic                      microproc_mode,
  output logic [ADDR_W-1:0]         addr_pin,
  output logic [DATA_W-1:0]         data_out,
  output logic [1:0]                data_oe,
  output logic [`XMBP_SPACES-1:0]   space_select_n,
  output logic                      read_strobe_n,
  output logic                      low_lane_store_strobe,
  output logic                      high_lane_store_strobe,
  output logic                      upper_lane_enable,
  output logic                      addr_latch,
  output logic                      bus_released_ack
);
  import xmbp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers; first stage feeds only the second
  logic hold_meta_reg, hold_sync_reg, rdy_meta_reg, rdy_sync_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_meta_reg <= `XMBP_IDLE_RST;
      hold_sync_reg <= `XMBP_IDLE_RST;
      rdy_meta_reg  <= 1'b1;
      rdy_sync_reg  <= 1'b1;
    end else begin
      hold_meta_reg <= hold_req_n;
      hold_sync_reg <= hold_meta_reg;
      rdy_meta_reg  <= ready;
      rdy_sync_reg  <= rdy_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // straps caught by clocked logic during reset
  logic wide3_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      wide3_reg      <= ~width_strap;
      microproc_mode <= boot_mode_strap;
    end
  end

  function automatic logic is_wide(input logic [1:0] sp, input logic [2:0] nar, input logic w3);
    is_wide = (sp == `XMBP_WIDE_SPACE) ? w3 : ~nar[sp];
  endfunction : is_wide

  ////////////////////////////////////////////////////////////////////////////
  xmbp_state_t   state_reg;
  logic          wr_reg, wide_reg, word_reg, mux_reg, single_reg;
  logic [1:0]    sp_reg;
  logic [ADDR_W-1:0] a_reg;
  logic [DATA_W-1:0] wd_reg;
  logic [1:0]        dcnt_reg;
  logic              in_addr, in_data, done;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= XMBP_IDLE;
      wr_reg <= 1'b0;
      wide_reg <= 1'b0;
      word_reg <= 1'b0;
      mux_reg <= 1'b0;
      single_reg <= 1'b0;
      sp_reg <= 2'h0;
      a_reg <= '0;
      wd_reg <= '0;
    end else begin
      case (state_reg)
        XMBP_IDLE: begin
          if (req_valid && req_ready) begin
            state_reg  <= XMBP_ADDR;
            wr_reg     <= req_write;
            sp_reg     <= req_space;
            a_reg      <= req_addr;
            wd_reg     <= req_wdata;
            word_reg   <= req_word & ~req_addr[0];
            wide_reg   <= is_wide(req_space, narrow_spaces, wide3_reg);
            mux_reg    <= (bus_mode == XMBP_MUXED);
            single_reg <= (strobe_scheme == XMBP_SINGLE_STROBE);
          end else if (!hold_sync_reg) begin
            state_reg <= XMBP_HOLD;
          end
        end
        XMBP_ADDR: state_reg <= XMBP_DATA;
        XMBP_DATA: begin
          if (done) begin
            state_reg <= XMBP_IDLE;
          end
        end
        XMBP_HOLD: begin
          if (hold_sync_reg) begin
            state_reg <= XMBP_IDLE;
          end
        end
        default: state_reg <= XMBP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, all registered
  assign in_addr = (state_reg == XMBP_ADDR);
  assign in_data = (state_reg == XMBP_DATA);
  assign done    = in_data && rdy_sync_reg && (dcnt_reg == `XMBP_DATA_MIN);

  ////////////////////////////////////////////////////////////////////////////
  // data phase floor: first synced ready samples predate the strobe,
  // so a slow part could not stall us without it; costs cycles per access
  always_ff @(posedge clock) begin
    if (rst) begin
      dcnt_reg <= 2'h0;
    end else if (!in_data) begin
      dcnt_reg <= 2'h0;
    end else if (dcnt_reg != `XMBP_DATA_MIN) begin
      dcnt_reg <= dcnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_pin <= {1'b1, {(ADDR_W-1){1'b0}}};
      data_out <= '0;
      data_oe <= 2'h0;
      space_select_n <= {`XMBP_SPACES{1'b1}};
      read_strobe_n <= 1'b1;
      low_lane_store_strobe <= 1'b1;
      high_lane_store_strobe <= 1'b1;
      upper_lane_enable <= 1'b1;
      addr_latch <= 1'b0;
      bus_released_ack <= 1'b1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      bus_released_ack <= ~(state_reg == XMBP_HOLD);
      req_ready <= (state_reg == XMBP_IDLE) && hold_sync_reg && microproc_mode
                   && !(req_valid && req_ready);
      rsp_valid <= done && !wr_reg;
      if (done && !wr_reg) begin
        rsp_rdata <= (wide_reg && (word_reg || a_reg[0])) ? data_in
                   : {8'h00, data_in[7:0]};
      end
      addr_pin <= {~a_reg[ADDR_W-1], a_reg[ADDR_W-2:0]};
      addr_latch <= in_addr;
      if (in_addr || in_data) begin
        space_select_n <= ~(`XMBP_SPACES'(1) << sp_reg);
      end else begin
        space_select_n <= {`XMBP_SPACES{1'b1}};
      end
      if (in_addr && mux_reg) begin
        data_out <= a_reg[DATA_W-1:0];
        data_oe  <= {wide_reg, 1'b1};
      end else if (in_data && wr_reg && !done) begin
        data_out <= (wide_reg && a_reg[0]) ? {wd_reg[7:0], 8'h00} : wd_reg;
        data_oe  <= {wide_reg, 1'b1};
      end else begin
        data_oe  <= 2'h0;
      end
      read_strobe_n <= ~(in_data && !wr_reg && !done);
      if (in_data && wr_reg && !done) begin
        if (single_reg) begin
          low_lane_store_strobe  <= 1'b0;
          high_lane_store_strobe <= 1'b1;
        end else begin
          low_lane_store_strobe  <= ~(!a_reg[0] || !wide_reg);
          high_lane_store_strobe <= ~(wide_reg && (a_reg[0] || word_reg));
        end
      end else begin
        low_lane_store_strobe  <= 1'b1;
        high_lane_store_strobe <= 1'b1;
      end
      upper_lane_enable <= ~((in_addr || in_data) && single_reg && (a_reg[0] || word_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_hold_ack: assert property (@(posedge clock) disable iff (rst)
    (state_reg == XMBP_HOLD) |=> !bus_released_ack)
    else $error("hold ack not low in hold");
  a_hold_stay: assert property (@(posedge clock) disable iff (rst)
    (state_reg == XMBP_HOLD && !hold_sync_reg) |=> state_reg == XMBP_HOLD)
    else $error("left hold while requested");
  a_ready_wait: assert property (@(posedge clock) disable iff (rst)
    (in_data && !rdy_sync_reg) |=> in_data)
    else $error("wait state not kept");
  a_addr_inv: assert property (@(posedge clock) disable iff (rst)
    addr_pin[ADDR_W-1] == ~$past(a_reg[ADDR_W-1]))
    else $error("top address bit not inverted");
  a_latch_pulse: assert property (@(posedge clock) disable iff (rst)
    addr_latch |-> ##1 !addr_latch)
    else $error("latch pulse too long");
  a_read_strobe: assert property (@(posedge clock) disable iff (rst)
    !read_strobe_n |-> !$past(wr_reg) && $past(in_data))
    else $error("read strobe outside read");
  a_space_sel: assert property (@(posedge clock) disable iff (rst)
    $onehot0(~space_select_n))
    else $error("more than one select");
  a_mux_addr: assert property (@(posedge clock) disable iff (rst)
    $past(in_addr && mux_reg) |-> data_oe[0] && data_out[7:0] == $past(a_reg[7:0]))
    else $error("mux address missing");
  a_odd_ube: assert property (@(posedge clock) disable iff (rst)
    $past(in_data && single_reg && a_reg[0]) |-> !upper_lane_enable)
    else $error("upper enable not low on odd");
  ////////////////////////////////////////////////////////////////////////////
  // hold, mode and request gating
  a_ack_high: assert property (@(posedge clock) disable iff (rst)
    (state_reg != XMBP_HOLD) |=> bus_released_ack)
    else $error("hold ack low outside hold");
  a_hold_entry: assert property (@(posedge clock) disable iff (rst)
    $past(state_reg == XMBP_IDLE && !hold_sync_reg && !(req_valid && req_ready))
      |-> state_reg == XMBP_HOLD)
    else $error("hold request not honoured");
  a_hold_quiet: assert property (@(posedge clock) disable iff (rst)
    $past(state_reg == XMBP_HOLD) |-> (&space_select_n) && read_strobe_n)
    else $error("bus driven in hold");
  a_ready_idle: assert property (@(posedge clock) disable iff (rst)
    req_ready |-> state_reg == XMBP_IDLE)
    else $error("request offered while busy");
  a_mode_take: assert property (@(posedge clock) disable iff (rst)
    (state_reg == XMBP_ADDR) |-> microproc_mode)
    else $error("access in single-chip mode");
  a_strap_keep: assert property (@(posedge clock) disable iff (rst)
    $stable(wide3_reg) && $stable(microproc_mode))
    else $error("strap value moved after reset");
  a_sync_hold: assert property (@(posedge clock) disable iff (rst)
    hold_sync_reg == $past(hold_meta_reg))
    else $error("hold synchroniser skipped");
  a_sync_rdy: assert property (@(posedge clock) disable iff (rst)
    rdy_sync_reg == $past(rdy_meta_reg))
    else $error("ready synchroniser skipped");

  ////////////////////////////////////////////////////////////////////////////
  // address, latch and select
  a_addr_low: assert property (@(posedge clock) disable iff (rst)
    addr_pin[ADDR_W-2:0] == $past(a_reg[ADDR_W-2:0]))
    else $error("low address bits not true");
  a_latch_follow: assert property (@(posedge clock) disable iff (rst)
    $past(in_addr) |-> addr_latch)
    else $error("latch pulse missing");
  a_latch_idle: assert property (@(posedge clock) disable iff (rst)
    !$past(in_addr) |-> !addr_latch)
    else $error("latch pulse outside address phase");
  a_sel_during: assert property (@(posedge clock) disable iff (rst)
    $past(in_addr || in_data) |-> !space_select_n[$past(sp_reg)])
    else $error("select missing during access");
  a_sel_idle: assert property (@(posedge clock) disable iff (rst)
    !$past(in_addr || in_data) |-> &space_select_n)
    else $error("select low outside access");
  a_mux_high: assert property (@(posedge clock) disable iff (rst)
    $past(in_addr && mux_reg && wide_reg)
      |-> data_oe[1] && data_out[15:8] == $past(a_reg[15:8]))
    else $error("upper mux address missing");
  a_mux_sep: assert property (@(posedge clock) disable iff (rst)
    $past(in_addr && !mux_reg) |-> data_oe == 2'h0)
    else $error("lanes driven in separate address phase");

  ////////////////////////////////////////////////////////////////////////////
  // data lanes and strobes
  a_narrow_oe: assert property (@(posedge clock) disable iff (rst)
    data_oe[1] |-> $past(wide_reg))
    else $error("upper lanes driven on narrow space");
  a_oe_write: assert property (@(posedge clock) disable iff (rst)
    $past(in_data && wr_reg && !done) |-> data_oe[0])
    else $error("write data not driven");
  a_oe_read: assert property (@(posedge clock) disable iff (rst)
    $past(in_data && !wr_reg) |-> data_oe == 2'h0)
    else $error("lanes driven during read");
  a_read_lanes: assert property (@(posedge clock) disable iff (rst)
    (rsp_valid && !wide_reg) |-> rsp_rdata[15:8] == 8'h00)
    else $error("narrow read not zero extended");
  a_wide_rd: assert property (@(posedge clock) disable iff (rst)
    (rsp_valid && wide_reg && word_reg) |-> rsp_rdata == $past(data_in))
    else $error("word read data wrong");
  a_split_even: assert property (@(posedge clock) disable iff (rst)
    $past(in_data && wr_reg && !done && !single_reg && wide_reg && !a_reg[0])
      |-> !low_lane_store_strobe)
    else $error("even write strobe missing");
  a_split_odd: assert property (@(posedge clock) disable iff (rst)
    $past(in_data && wr_reg && !done && !single_reg && wide_reg && a_reg[0])
      |-> !high_lane_store_strobe && low_lane_store_strobe)
    else $error("odd write strobe wrong");
  a_single_wr: assert property (@(posedge clock) disable iff (rst)
    $past(in_data && wr_reg && !done && single_reg)
      |-> !low_lane_store_strobe && high_lane_store_strobe)
    else $error("single write strobe wrong");
  a_ube_even: assert property (@(posedge clock) disable iff (rst)
    $past((in_addr || in_data) && single_reg && !a_reg[0] && !word_reg)
      |-> upper_lane_enable)
    else $error("upper enable low on even byte");
  a_write_no_read: assert property (@(posedge clock) disable iff (rst)
    !low_lane_store_strobe |-> read_strobe_n)
    else $error("read and write strobe together");
  a_idle_quiet: assert property (@(posedge clock) disable iff (rst)
    $past(state_reg == XMBP_IDLE)
      |-> read_strobe_n && low_lane_store_strobe && high_lane_store_strobe)
    else $error("strobe active while idle");
  a_rsp_pulse: assert property (@(posedge clock) disable iff (rst)
    rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_data_floor: assert property (@(posedge clock) disable iff (rst)
    (in_data && dcnt_reg != `XMBP_DATA_MIN) |=> in_data)
    else $error("data phase cut short");
  a_store_end: assert property (@(posedge clock) disable iff (rst)
    $past(done) |-> low_lane_store_strobe && high_lane_store_strobe && read_strobe_n)
    else $error("strobe kept after ready");

  c_read: cover property (@(posedge clock) !read_strobe_n);
  c_write: cover property (@(posedge clock) !low_lane_store_strobe);
  c_hold: cover property (@(posedge clock) !bus_released_ack);
  c_wait: cover property (@(posedge clock) in_data && !rdy_sync_reg);
  c_mux: cover property (@(posedge clock) $past(in_addr && mux_reg) && data_oe[1]);
endmodule : xmbp_port
`default_nettype wire

// >>> xmbp_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module xmbp_mem_model (
  input  wire logic        clock,
  input  wire logic        read_strobe_n,
  input  wire logic [23:0] addr_pin,
  input  wire logic [3:0]  stall,
  output logic             ready,
  output logic [15:0]      data_in
);
  logic [3:0]  cnt_reg;
  logic [15:0] last_reg;
  always_ff @(posedge clock) begin
    if (read_strobe_n) cnt_reg <= 4'h0;
    else if (cnt_reg != stall) cnt_reg <= cnt_reg + 4'h1;
  end
  // slow part: ready held low until the stall count has run out
  assign ready = read_strobe_n || (cnt_reg == stall);
  // released lanes toggle so a stale value never looks valid
  assign data_in = read_strobe_n ? ~last_reg : {addr_pin[7:0] ^ 8'h5A, addr_pin[7:0]};
  always_ff @(posedge clock) last_reg <= data_in;
endmodule : xmbp_mem_model
`default_nettype wire

// >>> test_external_memory_bus_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_external_memory_bus_port;
  import xmbp_pkg::*;
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_word = 1'b0;
  logic [1:0] req_space = 2'h0, data_oe;
  logic [23:0] req_addr = 24'h000000, addr_pin, lat_addr;
  logic [15:0] req_wdata = 16'h0000, data_in, rsp_rdata, data_out, lat_dout, rdata, wr_dout;
  xmbp_strobe_t strobe_scheme = XMBP_SINGLE_STROBE;
  xmbp_busmode_t bus_mode = XMBP_SEPARATE;
  logic [2:0] narrow_spaces = 3'h2;
  logic width_strap = 1'b0, boot_mode_strap = 1'b1, hold_req_n = 1'b1;
  logic [3:0] stall = 4'h0, space_select_n, lat_sel;
  logic ready, req_ready, rsp_valid, microproc_mode, read_strobe_n, addr_latch;
  logic low_lane_store_strobe, high_lane_store_strobe, upper_lane_enable, bus_released_ack;
  logic saw_lo, saw_hi, saw_ube;
  int rd_cycles, miscompares = 0, compares = 0;
  always #2.5 clock = ~clock;
  xmbp_port DUT (.clock, .rst, .req_valid, .req_write, .req_space, .req_addr, .req_wdata,
    .req_word, .strobe_scheme, .bus_mode, .narrow_spaces, .width_strap, .boot_mode_strap,
    .hold_req_n, .ready, .data_in, .req_ready, .rsp_valid, .rsp_rdata, .microproc_mode,
    .addr_pin, .data_out, .data_oe, .space_select_n, .read_strobe_n, .low_lane_store_strobe,
    .high_lane_store_strobe, .upper_lane_enable, .addr_latch, .bus_released_ack);
  xmbp_mem_model mem (.clock, .read_strobe_n, .addr_pin, .stall, .ready, .data_in);
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (req_valid && req_ready) begin
      {saw_lo, saw_hi, saw_ube} <= 3'h0;
      rd_cycles <= 0;
    end else begin
      if (!low_lane_store_strobe) saw_lo <= 1'b1;
      if (!high_lane_store_strobe) saw_hi <= 1'b1;
      if (!upper_lane_enable) saw_ube <= 1'b1;
      if (!read_strobe_n) rd_cycles <= rd_cycles + 1;
      if (addr_latch) {lat_addr, lat_dout, lat_sel} <= {addr_pin, data_out, space_select_n};
      if (!low_lane_store_strobe) wr_dout <= data_out;
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic bail(input int n);
    if (n >= 99) begin
      miscompares++;
      wrap_up();
    end
  endtask : bail
  // straps are only caught while reset is high, so they change only here
  task automatic do_reset(input logic mode, input logic narrow3);
    rst <= 1'b1;
    boot_mode_strap <= mode;
    width_strap <= narrow3;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : do_reset
  task automatic access(input logic wr, input logic [1:0] sp, input logic [23:0] a,
                        input logic word, input logic [15:0] wd);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_space <= sp;
    req_addr <= a;
    req_word <= word;
    req_wdata <= wd;
    do @(posedge clock); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    do @(posedge clock); while ((wr ? req_ready : rsp_valid) !== 1'b1 && ++n < 99);
    rdata = rsp_rdata;
    bail(n);
  endtask : access
  task automatic wait_ack(input logic v);
    int n;
    n = 50;
    do @(posedge clock); while (bus_released_ack !== v && ++n < 99);
    bail(n);
  endtask : wait_ack
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b1, 1'b0);
    check(bus_released_ack, 1'b1);
    check(addr_pin, 24'h800000);
    check(space_select_n, 4'hF);
    check(microproc_mode, 1'b1);
    stall <= 4'h3;
    access(1'b0, 2'h0, 24'h000010, 1'b1, 16'h0000);
    check(rdata, 16'h4A10);
    check(lat_addr, 24'h800010);
    check(lat_sel, 4'hE);
    check(rd_cycles >= 3, 1'b1);
    stall <= 4'h0;
    access(1'b0, 2'h1, 24'h800020, 1'b0, 16'h0000);
    check(rdata, 16'h0020);
    check(lat_addr, 24'h000020);
    check(rd_cycles > 0, 1'b1);
    access(1'b0, 2'h3, 24'h000030, 1'b1, 16'h0000);
    check(rdata, 16'h6A30);
    check(lat_sel, 4'h7);
    strobe_scheme <= XMBP_SPLIT_STROBE;
    access(1'b1, 2'h0, 24'h000040, 1'b0, 16'h00A5);
    check({saw_lo, saw_hi}, 2'b10);
    check(wr_dout, 16'h00A5);
    access(1'b1, 2'h0, 24'h000041, 1'b0, 16'hA500);
    check({saw_lo, saw_hi}, 2'b01);
    strobe_scheme <= XMBP_SINGLE_STROBE;
    access(1'b1, 2'h0, 24'h000043, 1'b0, 16'h3C00);
    check({saw_lo, saw_ube}, 2'b11);
    access(1'b1, 2'h0, 24'h000044, 1'b0, 16'h00C3);
    check({saw_lo, saw_ube}, 2'b10);
    bus_mode <= XMBP_MUXED;
    access(1'b1, 2'h2, 24'h001234, 1'b1, 16'hBEEF);
    check(lat_dout, 16'h1234);
    check(lat_addr, 24'h801234);
    check(lat_sel, 4'hB);
    bus_mode <= XMBP_SEPARATE;
    hold_req_n <= 1'b0;
    wait_ack(1'b0);
    repeat (10) @(posedge clock);
    check(bus_released_ack, 1'b0);
    check(req_ready, 1'b0);
    hold_req_n <= 1'b1;
    wait_ack(1'b1);
    check(bus_released_ack, 1'b1);
    do_reset(1'b0, 1'b1);
    check({microproc_mode, req_ready}, 2'b00);
    do_reset(1'b1, 1'b1);
    access(1'b0, 2'h3, 24'h000050, 1'b1, 16'h0000);
    check(rdata, 16'h0050);
    wrap_up();
  end
endmodule : test_external_memory_bus_port
`default_nettype wire
